/* File: src/alpc_pkg.sv */
// package of constants and types for the access level protection checker
package alpc_pkg;
   localparam int ALPC_AW = 32;
   localparam int ALPC_LW = 3;
   localparam int ALPC_DTW = 2;
   // descriptor types
   localparam logic [1:0] ALPC_DT_INVALID = 2'h0;
   localparam logic [1:0] ALPC_DT_PAGE = 2'h1;
   // level count select codes
   localparam logic [1:0] ALPC_LC_ONE = 2'h1;
   localparam logic [1:0] ALPC_LC_TWO = 2'h2;
   localparam logic [1:0] ALPC_LC_THREE = 2'h3;
   // function code space codes
   localparam logic [2:0] ALPC_FC_UDATA = 3'h1;
   localparam logic [2:0] ALPC_FC_UPROG = 3'h2;
   localparam logic [2:0] ALPC_FC_SDATA = 3'h5;
   localparam logic [2:0] ALPC_FC_SPROG = 3'h6;
   localparam int ALPC_FC_S_BIT = 2;
   // apb register byte offsets
   localparam logic [7:0] ALPC_OFF_CTRL = 8'h00;
   localparam logic [7:0] ALPC_OFF_LEVEL = 8'h04;
   localparam logic [7:0] ALPC_OFF_STAT = 8'h08;
   localparam logic [7:0] ALPC_OFF_MASK = 8'h0C;
   localparam logic [7:0] ALPC_OFF_FCT = 8'h10;
   localparam logic [7:0] ALPC_OFF_LAST = 8'h14;
   // control register fields
   localparam int ALPC_CTL_EN = 0;
   localparam int ALPC_CTL_FCL = 1;
   localparam int ALPC_CTL_LC = 2;
   localparam int ALPC_CTL_GRANT = 4;
   // status events
   localparam int ALPC_NEV = 4;
   localparam int ALPC_EV_INV = 0;
   localparam int ALPC_EV_LEVEL = 1;
   localparam int ALPC_EV_PRIV = 2;
   localparam int ALPC_EV_CALL = 3;
   // fault causes
   typedef enum logic [2:0] {
      ALPC_F_NONE = 3'h0,
      ALPC_F_INVALID = 3'h1,
      ALPC_F_LEVEL = 3'h2,
      ALPC_F_SUPER = 3'h3,
      ALPC_F_WRITE = 3'h4,
      ALPC_F_ENTRY = 3'h5
   } alpc_fault_t;
   localparam logic [2:0] ALPC_LVL_RST = 3'h0;
   localparam logic [31:0] ALPC_ZERO32 = 32'h0000_0000;
endpackage

/* File: src/alpc_walk_acc.sv */
// accumulates protection attributes over the descriptors of one table walk
`timescale 1ns/10ps
module alpc_walk_acc
   import alpc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic walk_start,
   input wire logic desc_valid,
   input wire logic [1:0] desc_type,
   input wire logic desc_long,
   input wire logic desc_super,
   input wire logic desc_wp,
   input wire logic [2:0] read_level_field,
   input wire logic [2:0] write_level_field,
   input wire logic [2:0] addr_level,
   output logic acc_err,
   output logic acc_wp,
   output logic acc_super
);
   logic err_d;
   logic wp_d;
   logic sup_d;
   always_comb begin
      err_d = walk_start ? 1'b0 : acc_err;
      wp_d = walk_start ? 1'b0 : acc_wp;
      sup_d = walk_start ? 1'b0 : acc_super;
      if (desc_valid) begin
         // invalid type sets the walk error for page or whole range; later descriptors still accumulate
         if (desc_type == ALPC_DT_INVALID) begin
            err_d = 1'b1;
         end
         if (desc_wp) begin
            wp_d = 1'b1;
         end
         if (desc_long) begin
            if (read_level_field < addr_level) begin
               err_d = 1'b1;
            end
            if (write_level_field < addr_level) begin
               wp_d = 1'b1;
            end
            if (desc_super) begin
               sup_d = 1'b1;
            end
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_err <= 1'b0;
         acc_wp <= 1'b0;
         acc_super <= 1'b0;
      end else begin
         acc_err <= err_d;
         acc_wp <= wp_d;
         acc_super <= sup_d;
      end
   end
endmodule

/* File: src/alpc_level_cmp.sv */
// extracts address level bits and compares them to the task level
`timescale 1ns/10ps
module alpc_level_cmp
   import alpc_pkg::*;
(
   input wire logic [31:0] laddr,
   input wire logic [1:0] level_count_select,
   input wire logic [2:0] task_level,
   output logic [2:0] addr_level,
   output logic too_privileged
);
   always_comb begin
      unique case (level_count_select)
         ALPC_LC_ONE: addr_level = {2'h0, laddr[ALPC_AW-1]};
         ALPC_LC_TWO: addr_level = {1'h0, laddr[ALPC_AW-1 -: 2]};
         ALPC_LC_THREE: addr_level = laddr[ALPC_AW-1 -: 3];
         default: addr_level = 3'h0;
      endcase
      // smaller value means more privilege; unsigned compare
      too_privileged = addr_level < task_level;
   end
endmodule

/* File: src/alpc_top.sv */
// access level protection checker with apb registers and interrupt
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/10ps
// Notes on behaviour
// - no translation is produced through a descriptor of invalid type; the access is denied.
// - an invalid type denies one page in a page descriptor and a whole range in a table pointer.
// - a supervisor-only flag lets only supervisor accesses reach the area.
// - a write-protect flag refuses writes from user and supervisor but allows reads.
// - with both flags an area is readable only by supervisor and writable by nobody.
// - with function code lookup on, data references take the user or supervisor data branch.
// - with function code lookup on, program references take the user or supervisor program branch.
// - two, four or eight levels are selectable within the user space.
// - a task at level n reaches areas of level n or less privilege and no more privileged ones.
// - a smaller level value is more privileged, level zero the most.
// - reads and writes are restricted separately, only in user space, by the task level; here walk level faults deny supervisor and dma cycles too.
// - module call and return change the task level only as the operating system allows.
// - the level count selects one, two or three level bits from the top of the address.
// - enabled user cycles whose address level is below the task level end in bus error.
// - on a walk a lower read level in a long descriptor sets the entry error flag, a lower write level there or wp sets its wp.
// - supervisor and dma cycles skip the task level check, but walks still check level fields.
module alpc_top
   import alpc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cyc_valid,
   input wire logic [31:0] cyc_laddr,
   input wire logic [2:0] cyc_fc,
   input wire logic supervisor_space_code,
   input wire logic dma_space_code,
   input wire logic cyc_write,
   input wire logic entry_hit,
   input wire logic entry_error_flag,
   input wire logic entry_wp,
   input wire logic entry_super,
   input wire logic walk_start,
   input wire logic desc_valid,
   input wire logic [1:0] desc_type,
   input wire logic desc_long,
   input wire logic desc_super,
   input wire logic desc_wp,
   input wire logic [2:0] read_level_field,
   input wire logic [2:0] write_level_field,
   input wire logic walk_done,
   input wire logic module_call_instr,
   input wire logic module_return_instr,
   input wire logic [2:0] call_target_level,
   output logic cyc_done,
   output logic cyc_bus_error,
   output logic [1:0] branch_sel,
   output logic walk_entry_valid,
   output logic walk_entry_error,
   output logic walk_entry_wp,
   output logic walk_entry_super,
   output logic irq
);
   logic ctl_en_q;
   logic ctl_fcl_q;
   logic [1:0] ctl_lc_q;
   logic [2:0] task_level_q;
   logic [2:0] ret_level_q;
   logic [ALPC_NEV-1:0] stat_q;
   logic [ALPC_NEV-1:0] mask_q;
   logic [7:0] fct_q;
   alpc_fault_t last_fault_q;
   logic [2:0] addr_level;
   logic too_priv;
   logic [2:0] walk_level;
   logic acc_err;
   logic acc_wp;
   logic acc_super;
   logic [ALPC_NEV-1:0] ev;
   logic apb_wr;
   logic apb_rd;
   logic is_super;
   logic lvl_checked;
   logic lvl_fault;
   logic inv_fault;
   logic priv_fault;
   logic call_ok;
   logic grant_q;
   alpc_fault_t fault_d;

   alpc_level_cmp u_cmp (
      .laddr(cyc_laddr),
      .level_count_select(ctl_lc_q),
      .task_level(task_level_q),
      .addr_level(addr_level),
      .too_privileged(too_priv)
   );

   // with the mechanism off no field can lie below level zero, so a walk raises no level fault
   assign walk_level = ctl_en_q ? addr_level : 3'h0;

   alpc_walk_acc u_walk (
      .pclk(pclk),
      .presetn(presetn),
      .walk_start(walk_start),
      .desc_valid(desc_valid),
      .desc_type(desc_type),
      .desc_long(desc_long),
      .desc_super(desc_super),
      .desc_wp(desc_wp),
      .read_level_field(read_level_field),
      .write_level_field(ctl_en_q ? write_level_field : 3'h7),
      .addr_level(walk_level),
      .acc_err(acc_err),
      .acc_wp(acc_wp),
      .acc_super(acc_super)
   );

   assign is_super = supervisor_space_code | cyc_fc[ALPC_FC_S_BIT];
   // dma walks still check level fields, only the task check is skipped
   assign lvl_checked = ctl_en_q & ~supervisor_space_code & ~dma_space_code;
   assign lvl_fault = lvl_checked & too_priv;
   assign inv_fault = entry_hit & entry_error_flag;
   // supervisor-only blocks user; wp blocks writes from both; together: supervisor read only
   assign priv_fault = entry_hit & ((entry_super & ~is_super) | (entry_wp & cyc_write));

   always_comb begin
      if (lvl_fault) begin
         fault_d = ALPC_F_LEVEL;
      end else if (inv_fault) begin
         fault_d = ALPC_F_INVALID;
      end else if (entry_hit & entry_super & ~is_super) begin
         fault_d = ALPC_F_SUPER;
      end else if (priv_fault) begin
         fault_d = ALPC_F_WRITE;
      end else begin
         fault_d = ALPC_F_NONE;
      end
   end

   // cycle result: one pulse per valid cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_done <= 1'b0;
         cyc_bus_error <= 1'b0;
         last_fault_q <= ALPC_F_NONE;
      end else begin
         cyc_done <= cyc_valid;
         cyc_bus_error <= cyc_valid & (fault_d != ALPC_F_NONE);
         if (cyc_valid & (fault_d != ALPC_F_NONE)) begin
            last_fault_q <= fault_d;
         end
      end
   end

   // table branch selection through the function code table
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         branch_sel <= 2'h0;
      end else if (cyc_valid) begin
         if (!ctl_fcl_q) begin
            branch_sel <= 2'h0;
         end else begin
            unique case (cyc_fc)
               ALPC_FC_UDATA: branch_sel <= fct_q[1:0];
               ALPC_FC_SDATA: branch_sel <= fct_q[5:4];
               ALPC_FC_UPROG: branch_sel <= fct_q[3:2];
               ALPC_FC_SPROG: branch_sel <= fct_q[7:6];
               default: branch_sel <= 2'h0;
            endcase
         end
      end
   end

   // walk result handed to the translation cache one cycle after walk_done
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         walk_entry_valid <= 1'b0;
         walk_entry_error <= 1'b0;
         walk_entry_wp <= 1'b0;
         walk_entry_super <= 1'b0;
      end else begin
         walk_entry_valid <= walk_done;
         if (walk_done) begin
            walk_entry_error <= acc_err;
            walk_entry_wp <= acc_wp;
            walk_entry_super <= acc_super;
         end
      end
   end

   // module call may only raise privilege from a supervisor cycle or when software has granted it
   assign call_ok = module_call_instr & (is_super | grant_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         task_level_q <= ALPC_LVL_RST;
         ret_level_q <= ALPC_LVL_RST;
      end else if (apb_wr && paddr == ALPC_OFF_LEVEL) begin
         task_level_q <= pwdata[2:0];
      end else if (call_ok && call_target_level <= task_level_q) begin
         ret_level_q <= task_level_q;
         task_level_q <= call_target_level;
      end else if (module_return_instr && ret_level_q >= task_level_q) begin
         task_level_q <= ret_level_q;
      end
   end

   assign ev[ALPC_EV_INV] = cyc_valid & inv_fault;
   assign ev[ALPC_EV_LEVEL] = cyc_valid & lvl_fault;
   assign ev[ALPC_EV_PRIV] = cyc_valid & priv_fault;
   assign ev[ALPC_EV_CALL] = module_call_instr & ~call_ok;

   // apb: zero wait state; reads sampled in setup so data stands with pready, writes taken in access
   assign apb_wr = psel & penable & pwrite;
   assign apb_rd = psel & ~penable & ~pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_en_q <= 1'b0;
         ctl_fcl_q <= 1'b0;
         ctl_lc_q <= ALPC_LC_ONE;
         grant_q <= 1'b0;
         mask_q <= '0;
         fct_q <= 8'h00;
      end else if (apb_wr) begin
         if (paddr == ALPC_OFF_CTRL) begin
            ctl_en_q <= pwdata[ALPC_CTL_EN];
            ctl_fcl_q <= pwdata[ALPC_CTL_FCL];
            // code zero is not a legal count; keep the old one
            if (pwdata[ALPC_CTL_LC +: 2] != 2'h0) begin
               ctl_lc_q <= pwdata[ALPC_CTL_LC +: 2];
            end
            grant_q <= pwdata[ALPC_CTL_GRANT];
         end
         if (paddr == ALPC_OFF_MASK) begin
            mask_q <= pwdata[ALPC_NEV-1:0];
         end
         if (paddr == ALPC_OFF_FCT) begin
            fct_q <= pwdata[7:0];
         end
      end
   end

   // sticky status: a new event wins over a write-one clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= '0;
      end else begin
         stat_q <= (stat_q & ~((apb_wr && paddr == ALPC_OFF_STAT) ? pwdata[ALPC_NEV-1:0] : '0)) | ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((stat_q & ~((apb_wr && paddr == ALPC_OFF_STAT) ? pwdata[ALPC_NEV-1:0] : '0)) | ev) & mask_q);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= ALPC_ZERO32;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & (paddr > ALPC_OFF_LAST || paddr[1:0] != 2'h0);
         if (apb_rd) begin
            unique case (paddr)
               ALPC_OFF_CTRL: prdata <= {27'h0, grant_q, ctl_lc_q, ctl_fcl_q, ctl_en_q};
               ALPC_OFF_LEVEL: prdata <= {29'h0, task_level_q};
               ALPC_OFF_STAT: prdata <= {28'h0, stat_q};
               ALPC_OFF_MASK: prdata <= {28'h0, mask_q};
               ALPC_OFF_FCT: prdata <= {24'h0, fct_q};
               ALPC_OFF_LAST: prdata <= {29'h0, last_fault_q};
               default: prdata <= ALPC_ZERO32;
            endcase
         end
      end
   end
endmodule

/* File: verif/alpc_core_model.sv */
// processor core model issuing logical bus cycles and module calls
`timescale 1ns/10ps
module alpc_core_model (
   input wire logic pclk,
   input wire logic cyc_done,
   input wire logic cyc_bus_error,
   output logic cyc_valid,
   output logic [31:0] cyc_laddr,
   output logic [2:0] cyc_fc,
   output logic supervisor_space_code,
   output logic dma_space_code,
   output logic cyc_write,
   output logic entry_hit,
   output logic entry_error_flag,
   output logic entry_wp,
   output logic entry_super,
   output logic module_call_instr,
   output logic module_return_instr,
   output logic [2:0] call_target_level
);
   initial begin
      {cyc_valid, supervisor_space_code, dma_space_code, cyc_write, entry_hit} = 5'h0;
      {entry_error_flag, entry_wp, entry_super, module_call_instr, module_return_instr} = 5'h0;
      {cyc_laddr, cyc_fc, call_target_level} = 38'h0;
   end
   task automatic bus(input logic [31:0] a, input logic [2:0] fc, input logic dma, w, ie, iw, es,
                      output logic d, be);
      @(posedge pclk);
      cyc_valid <= 1'h1;
      cyc_laddr <= a;
      cyc_fc <= fc;
      supervisor_space_code <= fc[2];
      dma_space_code <= dma;
      cyc_write <= w;
      entry_hit <= 1'h1;
      {entry_error_flag, entry_wp, entry_super} <= {ie, iw, es};
      @(posedge pclk);
      cyc_valid <= 1'h0;
      // a released address bus must not keep showing the last value
      cyc_laddr <= ~a;
      #1;
      d = cyc_done;
      be = cyc_bus_error;
   endtask
   task automatic hold(input logic [31:0] a);
      @(posedge pclk);
      cyc_laddr <= a;
   endtask
   task automatic call(input logic [2:0] tgt, input logic sup);
      @(posedge pclk);
      module_call_instr <= 1'h1;
      call_target_level <= tgt;
      supervisor_space_code <= sup;
      @(posedge pclk);
      module_call_instr <= 1'h0;
      call_target_level <= ~tgt;
   endtask
   task automatic ret();
      @(posedge pclk);
      module_return_instr <= 1'h1;
      @(posedge pclk);
      module_return_instr <= 1'h0;
   endtask
endmodule

/* File: verif/alpc_top_sva.sv */
// assertions on the bus cycle and walk ports of the protection checker
`timescale 1ns/10ps
module alpc_top_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cyc_valid,
   input wire logic supervisor_space_code,
   input wire logic dma_space_code,
   input wire logic cyc_write,
   input wire logic entry_hit,
   input wire logic entry_error_flag,
   input wire logic entry_wp,
   input wire logic entry_super,
   input wire logic cyc_done,
   input wire logic cyc_bus_error,
   input wire logic walk_done,
   input wire logic walk_entry_valid
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic hit;
   assign hit = cyc_valid && entry_hit;
   property p_done; cyc_valid ##1 !cyc_valid |-> cyc_done ##1 !cyc_done; endproperty
   a_done: assert property (p_done) else $error("cycle answer not a single pulse");
   property p_quiet; !cyc_valid |=> !cyc_done && !cyc_bus_error; endproperty
   a_quiet: assert property (p_quiet) else $error("answer without a cycle");
   property p_inv; hit && entry_error_flag |=> cyc_bus_error; endproperty
   a_inv: assert property (p_inv) else $error("invalid entry passed");
   property p_super; hit && entry_super && !supervisor_space_code |=> cyc_bus_error; endproperty
   a_super: assert property (p_super) else $error("user reached supervisor area");
   property p_wp; hit && entry_wp && cyc_write |-> ##1 cyc_bus_error; endproperty
   a_wp: assert property (p_wp) else $error("write to protected area passed");
   property p_both; hit && entry_super && entry_wp && !(supervisor_space_code && !cyc_write) |=> cyc_bus_error;
   endproperty
   a_both: assert property (p_both) else $error("supervisor read-only area misused");
   property p_skip;
      hit && !entry_error_flag && !(entry_wp && cyc_write) && !(entry_super && !supervisor_space_code)
      && (supervisor_space_code || dma_space_code) |=> !cyc_bus_error;
   endproperty
   a_skip: assert property (p_skip) else $error("privileged cycle refused");
   property p_walk; walk_done |=> walk_entry_valid ##1 !walk_entry_valid; endproperty
   a_walk: assert property (p_walk) else $error("walk entry not delivered");
endmodule
bind alpc_top alpc_top_sva u_sva (.pclk, .presetn, .cyc_valid, .supervisor_space_code, .dma_space_code,
   .cyc_write, .entry_hit, .entry_error_flag, .entry_wp, .entry_super, .cyc_done, .cyc_bus_error, .walk_done,
   .walk_entry_valid);

/* File: verif/alpc_top_test.sv */
// self-checking bench for the access level protection checker
`timescale 1ns/10ps
module alpc_top_test
   import alpc_pkg::*;
;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00, fct;
   logic [31:0] pwdata = 32'h0, prdata, rd, a, cyc_laddr;
   logic pready, pslverr, rerr, cyc_valid, supervisor_space_code, dma_space_code, cyc_write, entry_hit;
   logic entry_error_flag, entry_wp, entry_super, module_call_instr, module_return_instr, cyc_done, cyc_bus_error;
   logic walk_start = 1'h0, desc_valid = 1'h0, desc_long = 1'h1, desc_super = 1'h0, desc_wp = 1'h0, walk_done = 1'h0;
   logic [1:0] desc_type = 2'h1, branch_sel, lc;
   logic [2:0] read_level_field = 3'h7, write_level_field = 3'h7, cyc_fc, call_target_level, tl, fc;
   logic walk_entry_valid, walk_entry_error, walk_entry_wp, walk_entry_super, irq, en, fcl, dma, w, ie, iw, es, d, be;
   int error_cnt = 0, tests_run = 0;
   alpc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .cyc_valid, .cyc_laddr, .cyc_fc, .supervisor_space_code, .dma_space_code, .cyc_write, .entry_hit,
      .entry_error_flag, .entry_wp, .entry_super, .walk_start, .desc_valid, .desc_type, .desc_long, .desc_super,
      .desc_wp, .read_level_field, .write_level_field, .walk_done, .module_call_instr, .module_return_instr,
      .call_target_level, .cyc_done, .cyc_bus_error, .branch_sel, .walk_entry_valid, .walk_entry_error,
      .walk_entry_wp, .walk_entry_super, .irq);
   alpc_core_model u_core (.pclk, .cyc_done, .cyc_bus_error, .cyc_valid, .cyc_laddr, .cyc_fc, .supervisor_space_code,
      .dma_space_code, .cyc_write, .entry_hit, .entry_error_flag, .entry_wp, .entry_super, .module_call_instr,
      .module_return_instr, .call_target_level);
   always #2 pclk = ~pclk;
   task automatic chk(input string nm, input logic [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      // only the watchdog ends a wait for pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // unsigned compare of the top address bits against the task level, user space only
   function automatic logic exp_err();
      logic [2:0] al;
      al = a[31:29] >> (2'h3 - lc);
      return (en && !fc[2] && !dma && al < tl) || ie || (es && !fc[2]) || (iw && w);
   endfunction
   task automatic run_cyc();
      apb(1'h1, ALPC_OFF_CTRL, (32'(lc) << ALPC_CTL_LC) | (32'(fcl) << ALPC_CTL_FCL) | 32'(en));
      apb(1'h1, ALPC_OFF_LEVEL, 32'(tl));
      apb(1'h1, ALPC_OFF_FCT, 32'(fct));
      u_core.bus(a, fc, dma, w, ie, iw, es, d, be);
      chk("done", 32'(d), 32'h1);
      chk("bus error", 32'(be), 32'(exp_err()));
      chk("branch", 32'(branch_sel), 32'(fcl ? fct[2 * {fc[2], fc[1]} +: 2] : 2'h0));
   endtask
   // two descriptors: the first carries the case, the second is a clean page
   task automatic walk(input logic [1:0] t, input logic s, p, input logic [2:0] rl, wl, ex);
      u_core.hold(32'h6000_0000);
      @(posedge pclk);
      walk_start <= 1'h1;
      @(posedge pclk);
      walk_start <= 1'h0;
      desc_valid <= 1'h1;
      {desc_type, desc_super, desc_wp, read_level_field, write_level_field} <= {t, s, p, rl, wl};
      @(posedge pclk);
      {desc_type, desc_super, desc_wp, read_level_field, write_level_field} <= {ALPC_DT_PAGE, 2'h0, 6'h3F};
      @(posedge pclk);
      desc_valid <= 1'h0;
      walk_done <= 1'h1;
      @(posedge pclk);
      walk_done <= 1'h0;
      #1;
      chk("walk entry", {walk_entry_valid, walk_entry_error, walk_entry_wp, walk_entry_super}, {1'h1, ex});
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h8764_3C3F));
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      for (int k = 0; k < 7; k++) begin
         if (k == 4) continue;
         apb(1'h0, 8'(4 * k), 32'h0);
         chk("reset value", rd, k == 0 ? 32'(ALPC_LC_ONE) << ALPC_CTL_LC : 32'h0);
         chk("slave error", 32'(rerr), k == 6 ? 32'h1 : 32'h0);
      end
      {en, fcl, lc, tl, fct, fc, dma, w, ie, iw, es} = {2'h2, ALPC_LC_THREE, 3'h4, 8'hE4, ALPC_FC_UDATA, 5'h0};
      for (int k = 3; k < 5; k++) begin
         a = {3'(k), 29'h0};
         run_cyc();
      end
      apb(1'h0, ALPC_OFF_STAT, 32'h0);
      chk("level fault status", rd, 32'h2);
      apb(1'h0, ALPC_OFF_LAST, 32'h0);
      chk("last fault", rd, 32'(ALPC_F_LEVEL));
      chk("irq masked", 32'(irq), 32'h0);
      apb(1'h1, ALPC_OFF_MASK, 32'h2);
      repeat (2) @(posedge pclk);
      chk("irq raised", 32'(irq), 32'h1);
      apb(1'h1, ALPC_OFF_STAT, 32'h2);
      repeat (2) @(posedge pclk);
      chk("irq cleared", 32'(irq), 32'h0);
      walk(ALPC_DT_INVALID, 1'h0, 1'h0, 3'h7, 3'h7, 3'h4);
      walk(ALPC_DT_PAGE, 1'h0, 1'h0, 3'h2, 3'h7, 3'h4);
      walk(ALPC_DT_PAGE, 1'h0, 1'h0, 3'h3, 3'h2, 3'h2);
      walk(ALPC_DT_PAGE, 1'h0, 1'h1, 3'h3, 3'h3, 3'h2);
      walk(ALPC_DT_PAGE, 1'h1, 1'h0, 3'h7, 3'h7, 3'h1);
      apb(1'h1, ALPC_OFF_CTRL, 32'h0C);
      walk(ALPC_DT_PAGE, 1'h0, 1'h0, 3'h0, 3'h0, 3'h0);
      apb(1'h1, ALPC_OFF_LEVEL, 32'h4);
      u_core.call(3'h2, 1'h0);
      apb(1'h0, ALPC_OFF_LEVEL, 32'h0);
      chk("call without grant", rd, 32'h4);
      apb(1'h0, ALPC_OFF_STAT, 32'h0);
      chk("call refused status", rd & 32'h8, 32'h8);
      apb(1'h1, ALPC_OFF_CTRL, 32'h1D);
      u_core.call(3'h2, 1'h0);
      apb(1'h0, ALPC_OFF_LEVEL, 32'h0);
      chk("granted call", rd, 32'h2);
      u_core.call(3'h6, 1'h0);
      apb(1'h0, ALPC_OFF_LEVEL, 32'h0);
      chk("call to lower privilege", rd, 32'h2);
      u_core.ret();
      apb(1'h0, ALPC_OFF_LEVEL, 32'h0);
      chk("return", rd, 32'h4);
      for (int i = 0; i < 80; i++) begin
         {en, fcl, w} = 3'($urandom);
         {ie, iw, es, dma} = 4'($urandom & $urandom);
         lc = 2'($urandom_range(3, 1));
         tl = 3'($urandom_range((1 << lc) - 1, 0));
         fct = 8'($urandom);
         a = $urandom;
         fc = {a[1], a[0], !a[0]};
         a = $urandom;
         run_cyc();
      end
      tally_and_finish();
   end
endmodule
